// ===== core/dll_map.vh
`ifndef DLL_MAP_VH
`define DLL_MAP_VH
// Behaviour
// - Every sent packet carries 32-bit link CRC
// - Bad link CRC makes us send NACK
// - Good link CRC makes us send ACK
// - Keep sent packets until acknowledged
// - ACK frees packets up to its sequence
// - Replay on NACK or replay timer expiry
// - Replay resends from oldest, original order
// - Exchange flow-control credits in link packets
// - Link packets guarded by 16-bit CRC

// Sequence numbering
`define SEQ_W        12
`define SEQ_MSB      11
`define SEQ_RESET    12'h000
`define ACKED_RESET  12'hfff

// Link CRC and link packet CRC
`define LCRC_POLY    32'h04c11db7
`define LCRC_INIT    32'hffffffff
`define DCRC_POLY    16'h100b
`define DCRC_INIT    16'hffff
`define DCRC_HI      15
`define DCRC_LO      0

// Link packet word layout: type in the top byte
`define DLLP_TYPE_HI 31
`define DLLP_TYPE_LO 24
`define DLLP_ACK     8'h00
`define DLLP_NACK    8'h10
`define DLLP_FC_INIT 8'h40
`define DLLP_FC_UPD  8'h80
`define FC_HDR_HI    19
`define FC_HDR_LO    12
`define FC_DATA_HI   11
`define FC_DATA_LO   0

// Timing
`define CLK_MHZ         250
`define REPLAY_TIME_NS  2000
`define FC_UPD_TIME_NS  4000
`endif

// ===== core/crc_step.v
`timescale 1ns/1ps
// One word of a serial CRC, unrolled per data bit, MSB first
module crc_step #(
  parameter             WIDTH  = 32,
  parameter             DATA_W = 32,
  parameter [WIDTH-1:0] POLY   = {WIDTH{1'b0}}
) (
  input  wire [WIDTH-1:0]  crc_in,
  input  wire [DATA_W-1:0] data,
  output wire [WIDTH-1:0]  crc_out
);
  wire [WIDTH-1:0] stage [0:DATA_W];

  assign stage[0] = crc_in;

  // Shift register step per bit; feedback folds in the polynomial
  genvar i;
  generate
    for (i = 0; i < DATA_W; i = i + 1) begin : g_bit
      wire fb;
      assign fb = stage[i][WIDTH-1] ^ data[DATA_W-1-i];
      assign stage[i+1] = {stage[i][WIDTH-2:0], 1'b0} ^ (fb ? POLY : {WIDTH{1'b0}});
    end
  endgenerate

  assign crc_out = stage[DATA_W];
endmodule // crc_step

// ===== core/link_retry.v
`timescale 1ns/1ps
`include "dll_map.vh"
module link_retry #(
  parameter        BUF_AW     = 6,
  parameter        TAB_AW     = 3,
  parameter [15:0] REPLAY_CYC = (`REPLAY_TIME_NS * `CLK_MHZ) / 1000,
  parameter [15:0] FC_CYC     = (`FC_UPD_TIME_NS * `CLK_MHZ) / 1000
) (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        tl_tx_valid,
  input  wire        tl_tx_sop,
  input  wire        tl_tx_eop,
  input  wire [31:0] tl_tx_data,
  output reg         tl_tx_ready,
  output reg         tl_rx_valid,
  output reg         tl_rx_sop,
  output reg         tl_rx_eop,
  output reg  [31:0] tl_rx_data,
  output reg         tl_rx_good,
  output reg         tl_rx_bad,
  input  wire [7:0]  fc_hdr_adv,
  input  wire [11:0] fc_data_adv,
  output reg  [7:0]  partner_hdr_credits,
  output reg  [11:0] partner_data_credits,
  output reg         partner_fc_valid,
  output reg         replay_active,
  input  wire        phy_link_up,
  output reg         phy_tx_valid,
  output reg         phy_tx_sop,
  output reg         phy_tx_eop,
  output reg         phy_tx_dllp,
  output reg  [31:0] phy_tx_data,
  input  wire        phy_rx_valid,
  input  wire        phy_rx_sop,
  input  wire        phy_rx_eop,
  input  wire        phy_rx_dllp,
  input  wire [31:0] phy_rx_data
);
  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_NEW    = 3'h1;
  localparam [2:0] S_LCRC   = 3'h2;
  localparam [2:0] S_REPLAY = 3'h3;
  localparam [2:0] S_DCRC   = 3'h4;
  localparam [BUF_AW:0]   LIM_RUN   = (1 << BUF_AW) - 2;
  localparam [BUF_AW:0]   LIM_START = (1 << BUF_AW) - 3;
  localparam [`SEQ_MSB:0] TAB_N     = 1 << TAB_AW;
  localparam [`SEQ_MSB:0] SEQ_ONE   = 1;
  localparam [BUF_AW:0]   PTR_ONE   = 1;

  reg  [2:0]          state_reg;
  reg  [2:0]          state_next;
  reg  [`SEQ_MSB:0]   next_seq_reg;
  reg  [`SEQ_MSB:0]   acked_seq_reg;
  reg  [BUF_AW:0]     head_reg;
  reg  [BUF_AW:0]     tail_reg;
  reg  [BUF_AW:0]     rd_reg;
  reg  [33:0]         buf_mem [0:(1<<BUF_AW)-1];
  reg  [BUF_AW:0]     start_tab [0:(1<<TAB_AW)-1];
  reg  [31:0]         lcrc_reg;
  reg  [15:0]         dcrc_hold_reg;
  reg  [15:0]         replay_tmr_reg;
  reg                 replay_pend_reg;
  reg  [15:0]         fc_tmr_reg;
  reg                 fc_pend_reg;
  reg  [19:0]         fc_sent_reg;
  reg                 ack_pend_reg;
  reg                 ack_nack_reg;
  reg  [`SEQ_MSB:0]   ack_seq_reg;
  reg  [`SEQ_MSB:0]   rx_seq_reg;
  reg  [`SEQ_MSB:0]   expect_reg;
  reg  [31:0]         rx_crc_reg;
  reg  [31:0]         hold_reg;
  reg                 hold_v_reg;
  reg                 first_reg;
  reg  [31:0]         rx_dllp_reg;
  reg  [15:0]         rx_dcrc_reg;
  // Transmit word chosen this cycle
  reg                 o_v;
  reg                 o_sop;
  reg                 o_eop;
  reg                 o_dl;
  reg  [31:0]         o_d;
  reg                 wr_en;
  reg                 sent_ack;
  reg                 sent_fc;
  reg                 start_new;
  reg                 start_replay;
  wire [BUF_AW:0]     used;
  wire [`SEQ_MSB:0]   tlp_out;
  wire                room_start;
  wire                ready_next;
  wire [31:0]         tx_crc_out;
  wire [15:0]         tx_dcrc_out;
  wire [31:0]         rx_crc_out;
  wire [15:0]         rx_dcrc_out;
  wire                dl_ok;
  wire [7:0]          dl_type;
  wire                ack_in;
  wire                nack_in;
  wire [`SEQ_MSB:0]   dist_s;
  wire [`SEQ_MSB:0]   dist_max;
  wire                release_ok;
  wire [`SEQ_MSB:0]   rel_next;
  wire                crc_ok;
  wire                rx_tlp_end;
  wire [7:0]          fc_type;

  assign used       = tail_reg - head_reg;
  assign tlp_out    = next_seq_reg - acked_seq_reg - SEQ_ONE;
  assign room_start = (used <= LIM_START) && (tlp_out < TAB_N);
  assign ready_next = (state_next == S_NEW) && (wr_en ? (used < LIM_RUN) : (used <= LIM_RUN));
  assign fc_type    = partner_fc_valid ? `DLLP_FC_UPD : `DLLP_FC_INIT;

  // CRC engines: new packets carry the link CRC, link packets the short one
  crc_step #(.WIDTH(32), .DATA_W(32), .POLY(`LCRC_POLY)) u_tx_lcrc (
    .crc_in  (state_reg == S_IDLE ? `LCRC_INIT : lcrc_reg),
    .data    (o_d),
    .crc_out (tx_crc_out)
  );
  crc_step #(.WIDTH(16), .DATA_W(32), .POLY(`DCRC_POLY)) u_tx_dcrc (
    .crc_in  (`DCRC_INIT),
    .data    (o_d),
    .crc_out (tx_dcrc_out)
  );
  crc_step #(.WIDTH(32), .DATA_W(32), .POLY(`LCRC_POLY)) u_rx_lcrc (
    .crc_in  (phy_rx_sop ? `LCRC_INIT : rx_crc_reg),
    .data    (phy_rx_data),
    .crc_out (rx_crc_out)
  );
  crc_step #(.WIDTH(16), .DATA_W(32), .POLY(`DCRC_POLY)) u_rx_dcrc (
    .crc_in  (`DCRC_INIT),
    .data    (phy_rx_data),
    .crc_out (rx_dcrc_out)
  );

  // Received link packet decode; a bad short CRC drops it silently
  assign dl_ok   = phy_rx_valid && phy_rx_dllp && phy_rx_eop &&
                   (phy_rx_data[`DCRC_HI:`DCRC_LO] == ~rx_dcrc_reg);
  assign dl_type = rx_dllp_reg[`DLLP_TYPE_HI:`DLLP_TYPE_LO];
  assign ack_in  = dl_ok && (dl_type == `DLLP_ACK || dl_type == `DLLP_NACK);
  assign nack_in = dl_ok && (dl_type == `DLLP_NACK);

  // Modulo distance keeps release correct across sequence wrap
  assign dist_s     = rx_dllp_reg[`SEQ_MSB:0] - acked_seq_reg;
  assign dist_max   = tlp_out;
  assign release_ok = ack_in && (dist_s != {`SEQ_W{1'b0}}) && (dist_s <= dist_max);
  assign rel_next   = rx_dllp_reg[`SEQ_MSB:0] + SEQ_ONE;

  assign crc_ok     = (phy_rx_data == ~rx_crc_reg);
  assign rx_tlp_end = phy_rx_valid && !phy_rx_dllp && phy_rx_eop && !phy_rx_sop;

  // Transmit arbiter: acknowledges first so the partner's timer stays quiet
  always @* begin
    state_next   = state_reg;
    o_v          = 1'b0;
    o_sop        = 1'b0;
    o_eop        = 1'b0;
    o_dl         = 1'b0;
    o_d          = 32'h0;
    wr_en        = 1'b0;
    sent_ack     = 1'b0;
    sent_fc      = 1'b0;
    start_new    = 1'b0;
    start_replay = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (phy_link_up) begin
          if (ack_pend_reg) begin
            o_v        = 1'b1;
            o_sop      = 1'b1;
            o_dl       = 1'b1;
            o_d        = {(ack_nack_reg ? `DLLP_NACK : `DLLP_ACK), 12'h0, ack_seq_reg};
            sent_ack   = 1'b1;
            state_next = S_DCRC;
          end else if (fc_pend_reg) begin
            o_v        = 1'b1;
            o_sop      = 1'b1;
            o_dl       = 1'b1;
            o_d        = {fc_type, 4'h0, fc_hdr_adv, fc_data_adv};
            sent_fc    = 1'b1;
            state_next = S_DCRC;
          end else if (replay_pend_reg && (used != {(BUF_AW+1){1'b0}})) begin
            start_replay = 1'b1;
            state_next   = S_REPLAY;
          end else if (tl_tx_valid && tl_tx_sop && room_start) begin
            o_v        = 1'b1;
            o_sop      = 1'b1;
            o_d        = {20'h0, next_seq_reg};
            wr_en      = 1'b1;
            start_new  = 1'b1;
            state_next = S_NEW;
          end
        end
      end
      S_NEW: begin
        if (tl_tx_valid && tl_tx_ready) begin
          o_v   = 1'b1;
          o_d   = tl_tx_data;
          wr_en = 1'b1;
          if (tl_tx_eop) begin
            state_next = S_LCRC;
          end
        end
      end
      S_LCRC: begin
        o_v        = 1'b1;
        o_eop      = 1'b1;
        o_d        = ~lcrc_reg;
        wr_en      = 1'b1;
        state_next = S_IDLE;
      end
      S_REPLAY: begin
        o_v   = 1'b1;
        o_sop = buf_mem[rd_reg[BUF_AW-1:0]][33];
        o_eop = buf_mem[rd_reg[BUF_AW-1:0]][32];
        o_d   = buf_mem[rd_reg[BUF_AW-1:0]][31:0];
        if (rd_reg + PTR_ONE == tail_reg) begin
          state_next = S_IDLE;
        end
      end
      S_DCRC: begin
        o_v        = 1'b1;
        o_eop      = 1'b1;
        o_dl       = 1'b1;
        o_d        = {16'h0, ~dcrc_hold_reg};
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Retry storage: the exact link words, so a replay is bit-identical
  always @(posedge ref_clk) begin
    if (wr_en) begin
      buf_mem[tail_reg[BUF_AW-1:0]] <= {o_sop, o_eop, o_d};
    end
    if (start_new) begin
      start_tab[next_seq_reg[TAB_AW-1:0]] <= tail_reg;
    end
  end

  // Transmit side state, release and replay control
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg       <= S_IDLE;
      next_seq_reg    <= `SEQ_RESET;
      acked_seq_reg   <= `ACKED_RESET;
      head_reg        <= {(BUF_AW+1){1'b0}};
      tail_reg        <= {(BUF_AW+1){1'b0}};
      rd_reg          <= {(BUF_AW+1){1'b0}};
      lcrc_reg        <= `LCRC_INIT;
      dcrc_hold_reg   <= `DCRC_INIT;
      replay_tmr_reg  <= 16'h0;
      replay_pend_reg <= 1'b0;
      fc_tmr_reg      <= 16'h0;
      fc_pend_reg     <= 1'b1;
      fc_sent_reg     <= 20'h0;
      tl_tx_ready     <= 1'b0;
      replay_active   <= 1'b0;
      phy_tx_valid    <= 1'b0;
      phy_tx_sop      <= 1'b0;
      phy_tx_eop      <= 1'b0;
      phy_tx_dllp     <= 1'b0;
      phy_tx_data     <= 32'h0;
    end else begin
      state_reg     <= state_next;
      tl_tx_ready   <= ready_next;
      replay_active <= (state_next == S_REPLAY);
      phy_tx_valid  <= o_v;
      phy_tx_sop    <= o_sop;
      phy_tx_eop    <= o_eop;
      phy_tx_dllp   <= o_dl;
      phy_tx_data   <= o_d;
      if (o_dl && o_sop) begin
        dcrc_hold_reg <= tx_dcrc_out;
      end
      if (wr_en) begin
        tail_reg <= tail_reg + PTR_ONE;
        lcrc_reg <= tx_crc_out;
      end
      if (start_new) begin
        next_seq_reg <= next_seq_reg + SEQ_ONE;
      end
      // Replay walks from the oldest held word up to the tail
      if (start_replay) begin
        rd_reg <= head_reg;
      end else if (state_reg == S_REPLAY) begin
        rd_reg <= rd_reg + PTR_ONE;
      end
      // Release everything up to and including the acknowledged number
      if (release_ok) begin
        acked_seq_reg <= rx_dllp_reg[`SEQ_MSB:0];
        head_reg      <= (rel_next == next_seq_reg) ? tail_reg : start_tab[rel_next[TAB_AW-1:0]];
      end
      // Timer restarts on any acknowledge and runs only with packets held
      if (ack_in || start_replay || tlp_out == {`SEQ_W{1'b0}}) begin
        replay_tmr_reg <= 16'h0;
      end else if (state_reg != S_REPLAY) begin
        replay_tmr_reg <= replay_tmr_reg + 16'h1;
      end
      // New triggers win over the clear taken at replay start
      if (nack_in || (replay_tmr_reg == REPLAY_CYC - 16'h1 && !ack_in)) begin
        replay_pend_reg <= 1'b1;
      end else if (start_replay || ack_in) begin
        replay_pend_reg <= 1'b0;
      end
      // Credits go out periodically and whenever the advertisement moves
      fc_tmr_reg <= sent_fc ? 16'h0 : fc_tmr_reg + 16'h1;
      if (fc_tmr_reg == FC_CYC - 16'h1 || {fc_hdr_adv, fc_data_adv} != fc_sent_reg) begin
        fc_pend_reg <= 1'b1;
      end else if (sent_fc) begin
        fc_pend_reg <= 1'b0;
      end
      if (sent_fc) begin
        fc_sent_reg <= {fc_hdr_adv, fc_data_adv};
      end
    end
  end

  // Receive side: data lags one word so the CRC word never reaches the user
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_seq_reg           <= `SEQ_RESET;
      expect_reg           <= `SEQ_RESET;
      rx_crc_reg           <= `LCRC_INIT;
      hold_reg             <= 32'h0;
      hold_v_reg           <= 1'b0;
      first_reg            <= 1'b0;
      rx_dllp_reg          <= 32'h0;
      rx_dcrc_reg          <= `DCRC_INIT;
      ack_pend_reg         <= 1'b0;
      ack_nack_reg         <= 1'b0;
      ack_seq_reg          <= `ACKED_RESET;
      tl_rx_valid          <= 1'b0;
      tl_rx_sop            <= 1'b0;
      tl_rx_eop            <= 1'b0;
      tl_rx_data           <= 32'h0;
      tl_rx_good           <= 1'b0;
      tl_rx_bad            <= 1'b0;
      partner_hdr_credits  <= 8'h0;
      partner_data_credits <= 12'h0;
      partner_fc_valid     <= 1'b0;
    end else begin
      tl_rx_valid <= 1'b0;
      tl_rx_good  <= 1'b0;
      tl_rx_bad   <= 1'b0;
      if (phy_rx_valid && !phy_rx_dllp) begin
        if (phy_rx_sop) begin
          rx_seq_reg <= phy_rx_data[`SEQ_MSB:0];
          rx_crc_reg <= rx_crc_out;
          hold_v_reg <= 1'b0;
          first_reg  <= 1'b1;
        end else begin
          if (hold_v_reg) begin
            tl_rx_valid <= 1'b1;
            tl_rx_sop   <= first_reg;
            tl_rx_eop   <= phy_rx_eop;
            tl_rx_data  <= hold_reg;
            first_reg   <= 1'b0;
          end
          if (phy_rx_eop) begin
            hold_v_reg <= 1'b0;
            tl_rx_good <= crc_ok && (rx_seq_reg == expect_reg);
            tl_rx_bad  <= !(crc_ok && (rx_seq_reg == expect_reg));
            if (crc_ok && rx_seq_reg == expect_reg) begin
              expect_reg <= expect_reg + SEQ_ONE;
            end
          end else begin
            rx_crc_reg <= rx_crc_out;
            hold_reg   <= phy_rx_data;
            hold_v_reg <= 1'b1;
          end
        end
      end
      // A verdict arriving as the last one leaves keeps the request alive
      if (rx_tlp_end) begin
        ack_pend_reg <= 1'b1;
        ack_nack_reg <= !crc_ok;
        ack_seq_reg  <= (crc_ok && rx_seq_reg == expect_reg) ? rx_seq_reg : expect_reg - SEQ_ONE;
      end else if (sent_ack) begin
        ack_pend_reg <= 1'b0;
      end
      if (phy_rx_valid && phy_rx_dllp && phy_rx_sop) begin
        rx_dllp_reg <= phy_rx_data;
        rx_dcrc_reg <= rx_dcrc_out;
      end
      if (dl_ok && (dl_type == `DLLP_FC_INIT || dl_type == `DLLP_FC_UPD)) begin
        partner_hdr_credits  <= rx_dllp_reg[`FC_HDR_HI:`FC_HDR_LO];
        partner_data_credits <= rx_dllp_reg[`FC_DATA_HI:`FC_DATA_LO];
        partner_fc_valid     <= 1'b1;
      end
    end
  end
endmodule // link_retry

// ===== verif/ref_calc.svh
// Bitwise CRC over one word, MSB first; w is 16 or 32
function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] d,
                                        input logic [31:0] p, input int w);
  logic fb;
  for (int i = 31; i >= 0; i--) begin
    fb = c[w-1] ^ d[i];
    c  = c << 1;
    if (fb)
      c = c ^ p;
  end
  return (w == 16) ? {16'h0, c[15:0]} : c;
endfunction

// Payload word i of packet seq, easy to recognise on a trace
function automatic logic [31:0] pat(input logic [11:0] seq, input int i);
  return {8'hd0, seq, i[11:0]};
endfunction

// ===== verif/link_retry_monitor.sv
`timescale 1ns/1ps
`include "dll_map.vh"
// Port-level watch on the retry block
module link_retry_monitor (
  input wire        ref_clk,
  input wire        arst_n,
  input wire        tl_tx_valid,
  input wire        tl_tx_eop,
  input wire [31:0] tl_tx_data,
  input wire        tl_tx_ready,
  input wire        tl_rx_valid,
  input wire        tl_rx_eop,
  input wire        tl_rx_good,
  input wire        tl_rx_bad,
  input wire        partner_fc_valid,
  input wire        phy_link_up,
  input wire        phy_tx_valid,
  input wire        phy_tx_sop,
  input wire        phy_tx_eop,
  input wire        phy_tx_dllp,
  input wire [31:0] phy_tx_data,
  input wire        phy_rx_valid,
  input wire        phy_rx_eop,
  input wire        phy_rx_dllp
);
`include "ref_calc.svh"
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Start of an outgoing link packet
  wire tx_lp = phy_tx_valid && phy_tx_sop && phy_tx_dllp;

  chk_down_silent: assert property (!phy_link_up |=> !phy_tx_valid)
    else $error("word sent while link is down");
  chk_seq_word: assert property (phy_tx_valid && phy_tx_sop && !phy_tx_dllp |-> phy_tx_data[31:12] == 20'h0)
    else $error("sequence word has stray upper bits");
  chk_lp_pair: assert property (tx_lp |=> phy_tx_valid && phy_tx_eop && phy_tx_dllp && !phy_tx_sop)
    else $error("link packet not two words");
  chk_lp_crc: assert property (tx_lp |=>
    {16'h0, ~phy_tx_data[15:0]} == crc_ref(`DCRC_INIT, $past(phy_tx_data), `DCRC_POLY, 16))
    else $error("link packet crc wrong");
  chk_word_passes: assert property (tl_tx_valid && tl_tx_ready |=>
    phy_tx_valid && !phy_tx_dllp && phy_tx_data == $past(tl_tx_data))
    else $error("taken word not forwarded next cycle");
  chk_eop_crc: assert property (tl_tx_valid && tl_tx_ready && tl_tx_eop |=>
    !tl_tx_ready ##1 (phy_tx_valid && phy_tx_eop && !phy_tx_dllp))
    else $error("crc word not after last word");
  chk_frame_gap: assert property (phy_tx_valid && phy_tx_eop |=> !phy_tx_valid || phy_tx_sop)
    else $error("word after frame end without start");
  chk_rx_verdict: assert property (phy_rx_valid && phy_rx_eop && !phy_rx_dllp |=>
    (tl_rx_good ^ tl_rx_bad) && tl_rx_valid && tl_rx_eop)
    else $error("no single verdict with last word");
  chk_verdict_once: assert property (tl_rx_good || tl_rx_bad |=> !(tl_rx_good || tl_rx_bad))
    else $error("verdict longer than one cycle");
  chk_fc_sticky: assert property (partner_fc_valid |=> partner_fc_valid)
    else $error("partner credits lost");
endmodule // link_retry_monitor

bind link_retry link_retry_monitor mon (.ref_clk(ref_clk), .arst_n(arst_n), .tl_tx_valid(tl_tx_valid),
  .tl_tx_eop(tl_tx_eop), .tl_tx_data(tl_tx_data), .tl_tx_ready(tl_tx_ready), .tl_rx_valid(tl_rx_valid),
  .tl_rx_eop(tl_rx_eop), .tl_rx_good(tl_rx_good), .tl_rx_bad(tl_rx_bad), .partner_fc_valid(partner_fc_valid),
  .phy_link_up(phy_link_up), .phy_tx_valid(phy_tx_valid), .phy_tx_sop(phy_tx_sop), .phy_tx_eop(phy_tx_eop),
  .phy_tx_dllp(phy_tx_dllp), .phy_tx_data(phy_tx_data), .phy_rx_valid(phy_rx_valid),
  .phy_rx_eop(phy_rx_eop), .phy_rx_dllp(phy_rx_dllp));

// ===== verif/link_partner.sv
`timescale 1ns/1ps
`include "dll_map.vh"
// Far-end link layer: sends on command, records all it hears
module link_partner (
  input  wire        ref_clk,
  input  wire        phy_tx_valid,
  input  wire        phy_tx_sop,
  input  wire        phy_tx_eop,
  input  wire        phy_tx_dllp,
  input  wire [31:0] phy_tx_data,
  output reg         phy_rx_valid,
  output reg         phy_rx_sop,
  output reg         phy_rx_eop,
  output reg         phy_rx_dllp,
  output reg  [31:0] phy_rx_data
);
`include "ref_calc.svh"
  logic [34:0] seen[$]; // {dllp, eop, sop, data}

  initial begin
    {phy_rx_valid, phy_rx_sop, phy_rx_eop, phy_rx_dllp, phy_rx_data} = 36'h0;
  end

  // Record every word the block puts on the link
  always @(posedge ref_clk)
    if (phy_tx_valid)
      seen.push_back({phy_tx_dllp, phy_tx_eop, phy_tx_sop, phy_tx_data});

  // One word, changed just after the edge
  task automatic put(input logic s, input logic e, input logic l, input logic [31:0] d);
    @(posedge ref_clk);
    {phy_rx_valid, phy_rx_sop, phy_rx_eop, phy_rx_dllp, phy_rx_data} <= {1'b1, s, e, l, d};
  endtask

  // Idle line shows the inverse, so a stale word is never reused
  task automatic rest;
    @(posedge ref_clk);
    {phy_rx_valid, phy_rx_sop, phy_rx_eop, phy_rx_dllp} <= 4'h0;
    phy_rx_data <= ~phy_rx_data;
  endtask

  // Packet: sequence word, n data words, inverted link CRC
  task automatic send_tlp(input logic [11:0] seq, input int n, input logic bad);
    logic [31:0] c;
    logic [31:0] d;
    d = {20'h0, seq};
    c = crc_ref(`LCRC_INIT, d, `LCRC_POLY, 32);
    put(1'b1, 1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      d = pat(seq, i);
      c = crc_ref(c, d, `LCRC_POLY, 32);
      put(1'b0, 1'b0, 1'b0, d);
    end
    put(1'b0, 1'b1, 1'b0, ~c ^ {31'h0, bad});
    rest;
  endtask

  // Link packet: word0, then inverted CRC16 of it
  task automatic send_lp(input logic [31:0] w, input logic bad);
    logic [31:0] c;
    c = crc_ref(`DCRC_INIT, w, `DCRC_POLY, 16);
    put(1'b1, 1'b0, 1'b1, w);
    put(1'b0, 1'b1, 1'b1, {16'h0, ~c[15:0] ^ {15'h0, bad}});
    rest;
  endtask
endmodule // link_partner

// ===== verif/link_retry_tb.sv
`timescale 1ns/1ps
`include "dll_map.vh"
module link_retry_tb;
`include "ref_calc.svh"
  logic        ref_clk, arst_n, phy_link_up, tl_tx_valid, tl_tx_sop, tl_tx_eop;
  logic [31:0] tl_tx_data;
  logic [7:0]  fc_hdr_adv;
  logic [11:0] fc_data_adv;
  wire         tl_tx_ready, tl_rx_valid, tl_rx_sop, tl_rx_eop, tl_rx_good, tl_rx_bad;
  wire         partner_fc_valid, replay_active, phy_tx_valid, phy_tx_sop, phy_tx_eop, phy_tx_dllp;
  wire         phy_rx_valid, phy_rx_sop, phy_rx_eop, phy_rx_dllp;
  wire [31:0]  tl_rx_data, phy_tx_data, phy_rx_data;
  wire [7:0]   partner_hdr_credits;
  wire [11:0]  partner_data_credits;
  int          mismatches, samples_checked, good_n, bad_n;
  logic        replay_seen, fdl;
  logic [31:0] rxd[$];
  logic [31:0] fw[$];

  // Short timer counts keep the run brief
  link_retry #(.REPLAY_CYC(16'd40), .FC_CYC(16'd60)) dut (.*);

  link_partner p (.*);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Collect delivered words and verdicts; sop folded into bit 31
  always @(posedge ref_clk) begin
    if (tl_rx_valid === 1'b1) rxd.push_back(tl_rx_data ^ {tl_rx_sop, 31'h0});
    if (tl_rx_good === 1'b1) good_n++;
    if (tl_rx_bad === 1'b1) bad_n++;
    if (replay_active === 1'b1) replay_seen = 1'b1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One whole frame off the wire, CRC checked
  task automatic get_frame;
    logic [34:0] x;
    logic [31:0] c;
    int          t;
    fw = {};
    c = `LCRC_INIT;
    do begin
      t = 0;
      while (p.seen.size() == 0) begin
        t++;
        if (t > 3000) begin
          mismatches++;
          test_done;
        end
        @(negedge ref_clk);
      end
      x = p.seen.pop_front();
      fw.push_back(x[31:0]);
    end while (x[33] !== 1'b1);
    fdl = x[34];
    if (fdl)
      check("lp crc", {16'h0, ~fw[1][15:0]}, crc_ref(`DCRC_INIT, fw[0], `DCRC_POLY, 16));
    else begin
      for (int i = 0; i < fw.size() - 1; i++)
        c = crc_ref(c, fw[i], `LCRC_POLY, 32);
      check("link crc", fw[fw.size()-1], ~c);
    end
  endtask

  // Skip unrelated frames until one with this kind and first word
  task automatic find(input logic dl, input logic [31:0] w);
    for (int k = 0; k < 30; k++) begin
      get_frame;
      if (fdl === dl && fw[0] === w)
        break;
    end
    check("frame word0", fw[0], w);
  endtask

  // Expect packet seq with n data words, in order
  task automatic expect_tlp(input logic [11:0] seq, input int n);
    find(1'b0, {20'h0, seq});
    check("frame size", fw.size(), n + 2);
    for (int i = 0; i < n; i++)
      check("frame data", fw[i+1], pat(seq, i));
  endtask

  // User-side valid/ready, ready read mid-cycle
  task automatic user_send(input logic [11:0] seq, input int n);
    int t;
    @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      tl_tx_valid <= 1'b1;
      tl_tx_sop   <= (i == 0);
      tl_tx_eop   <= (i == n - 1);
      tl_tx_data  <= pat(seq, i);
      t = 0;
      do begin
        @(negedge ref_clk);
        t++;
        if (t > 2000) begin
          mismatches++;
          test_done;
        end
      end while (tl_tx_ready !== 1'b1);
      @(posedge ref_clk);
    end
    tl_tx_valid <= 1'b0;
  endtask

  task automatic s_quiet;
    repeat (10) @(negedge ref_clk);
    check("sent while down", p.seen.size(), 0);
    @(posedge ref_clk);
    phy_link_up <= 1'b1;
  endtask

  task automatic s_credits;
    find(1'b1, {`DLLP_FC_INIT, 4'h0, 8'h21, 12'h345});
    p.send_lp({`DLLP_FC_INIT, 4'h0, 8'h1a, 12'h2b3}, 1'b0);
    for (int t = 0; partner_fc_valid !== 1'b1 && t < 50; t++)
      @(negedge ref_clk);
    check("fc valid", partner_fc_valid, 1'b1);
    check("credits", {partner_hdr_credits, partner_data_credits}, {8'h1a, 12'h2b3});
    p.send_lp({`DLLP_FC_UPD, 4'h0, 8'h77, 12'h777}, 1'b1);
    repeat (20) @(negedge ref_clk);
    check("corrupt credits", {partner_hdr_credits, partner_data_credits}, {8'h1a, 12'h2b3});
    @(posedge ref_clk);
    fc_hdr_adv <= 8'h22;
    find(1'b1, {`DLLP_FC_UPD, 4'h0, 8'h22, 12'h345});
  endtask

  task automatic s_rx;
    rxd = {};
    p.send_tlp(12'h000, 2, 1'b0);
    find(1'b1, {`DLLP_ACK, 24'h000});
    check("rx count", rxd.size(), 2);
    check("rx word0", rxd[0], pat(12'h000, 0) ^ 32'h80000000);
    check("rx word1", rxd[1], pat(12'h000, 1));
    p.send_tlp(12'h001, 1, 1'b1);
    find(1'b1, {`DLLP_NACK, 24'h000});
    check("bad verdicts", bad_n, 1);
    p.send_tlp(12'h001, 3, 1'b0);
    find(1'b1, {`DLLP_ACK, 24'h001});
    p.send_tlp(12'h001, 1, 1'b0);
    find(1'b1, {`DLLP_ACK, 24'h001});
    check("verdicts", {good_n[7:0], bad_n[7:0]}, 16'h0202);
  endtask

  task automatic s_tx;
    for (int k = 0; k < 3; k++) begin
      user_send(k[11:0], k + 1);
      expect_tlp(k[11:0], k + 1);
    end
    replay_seen = 1'b0;
    p.send_lp({`DLLP_NACK, 24'h000}, 1'b0);
    expect_tlp(12'h001, 2);
    expect_tlp(12'h002, 3);
    check("nack replay", replay_seen, 1'b1);
    p.send_lp({`DLLP_ACK, 24'h002}, 1'b0);
    repeat (20) @(negedge ref_clk);
    replay_seen = 1'b0;
    repeat (150) @(negedge ref_clk);
    check("replay after release", replay_seen, 1'b0);
    user_send(12'h003, 1);
    expect_tlp(12'h003, 1);
    replay_seen = 1'b0;
    expect_tlp(12'h003, 1);
    check("timer replay", replay_seen, 1'b1);
    p.send_lp({`DLLP_ACK, 24'h003}, 1'b0);
  endtask

  initial begin
    {arst_n, phy_link_up, tl_tx_valid, tl_tx_sop, tl_tx_eop} = 5'h0;
    tl_tx_data  = 32'h0;
    fc_hdr_adv  = 8'h21;
    fc_data_adv = 12'h345;
    replay_seen = 1'b0;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    s_quiet;
    s_credits;
    s_rx;
    s_tx;
    test_done;
  end
endmodule // link_retry_tb
